/* rtl/fsp_pkg.sv */
// Shared constants for the flash self-program sequencer and its core end.
// Assumes a single 200 MHz clock and an active-high asynchronous reset.
package fsp_pkg;
	// ************************************************
	// Array geometry
	// ************************************************
	localparam int ROW_WORDS  = 64;  // Words per row and per holding buffer
	localparam int PAGE_WORDS = 512; // Eight rows per erase page
	localparam int SLOT_LSB   = 1;   // Word slot within row, address bits 6:1
	localparam int ROW_LSB    = 7;   // Row number starts at address bit 7
	localparam int PAGE_LSB   = 10;  // Page number starts at address bit 10
	localparam logic [23:0] ERASED_WORD = 24'hffffff;
	// ************************************************
	// Timing
	// ************************************************
	localparam int SYS_KHZ     = 200000; // System clock rate
	localparam int FRC_KHZ     = 7370;   // Internal fast RC rate
	localparam int FRC_DIV     = SYS_KHZ / FRC_KHZ; // System cycles per RC tick
	localparam int ROW_TICKS   = 11064; // Row write length in RC ticks
	localparam int WORD_TICKS  = 400;   // Word write length, plain default
	localparam int ERASE_TICKS = 4000;  // Page erase length, plain default
	// ************************************************
	// Device registers and fields
	// ************************************************
	localparam logic [1:0] SEL_PAGE = 2'h0; // Table page select
	localparam logic [1:0] SEL_CTRL = 2'h1; // Flash op control
	localparam logic [1:0] SEL_KEY  = 2'h2; // Flash unlock key
	localparam int CTL_START = 15;
	localparam int CTL_EN    = 14;
	localparam int CTL_ERR   = 13;
	localparam int CTL_ERASE = 6;
	localparam logic [3:0] OP_ROW  = 4'h1; // Erase bit clear
	localparam logic [3:0] OP_WORD = 4'h3; // Erase bit clear
	localparam logic [3:0] OP_PAGE = 4'h2; // Erase bit set
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	typedef enum logic [1:0] {K_REG_WR, K_REG_RD, K_TBL_WR, K_TBL_RD} fsp_kind_type;
	typedef enum logic [1:0] {KS_IDLE = 2'b00, KS_HALF = 2'b01, KS_ARMED = 2'b11} fsp_key_type;
	// ************************************************
	// Core-end APB map and commands
	// ************************************************
	localparam logic [7:0] A_CMD    = 8'h00;
	localparam logic [7:0] A_ADDR   = 8'h04;
	localparam logic [7:0] A_WDATA  = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_RDATA  = 8'h10;
	localparam logic [2:0] CMD_LOAD  = 3'h1;
	localparam logic [2:0] CMD_ROW   = 3'h2;
	localparam logic [2:0] CMD_WORD  = 3'h3;
	localparam logic [2:0] CMD_ERASE = 3'h4;
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam int ST_BUSY    = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_IDX_LSB = 8;
endpackage : fsp_pkg

/* rtl/fsp_link_if.sv */
// Request link between the core end and the flash sequencer.
// Assumes both ends share sys_clk; the testbench joins them.
`timescale 1ns/1ps
interface fsp_link_if;
	logic                 req;           // Request held until ack
	fsp_pkg::fsp_kind_type kind;         // Register or table, read or write
	logic [1:0]           regSel;        // Register select
	logic                 high;          // Table high half
	logic                 byteMode;      // Byte sized table access
	logic                 byteSel;       // Upper byte when set
	logic [15:0]          ea;            // Effective address
	logic [15:0]          wdata;         // Write data
	logic                 ack;           // One-cycle answer
	logic [15:0]          rdata;         // Read data, valid with ack
	logic                 stall;         // Core held while high
	logic                 windowSuspend; // Data window off during table ops
	modport dev (input req, kind, regSel, high, byteMode, byteSel, ea, wdata,
		output ack, rdata, stall, windowSuspend);
	modport core (output req, kind, regSel, high, byteMode, byteSel, ea, wdata,
		input ack, rdata, stall, windowSuspend);
endinterface : fsp_link_if

/* rtl/fsp_tick_div.sv */
// Divider giving one-cycle pulses at the internal fast RC rate.
// Assumes en is a level; the phase restarts whenever en is low.
`timescale 1ns/1ps
module fsp_tick_div #(
	parameter int DIV = fsp_pkg::FRC_DIV
) (
	input  wire logic sys_clk, // System clock
	input  wire logic rst,     // Async reset
	input  wire logic en,      // Count while high
	output logic      tick     // One pulse per DIV cycles
);
	// ************************************************
	// Divider state
	// ************************************************
	typedef struct packed {
		logic [7:0] cnt; // Cycles into the period
	} fsp_div_state_type;
	fsp_div_state_type cur_r, cur_nxt;
	// Eight-bit phase counter caps the ratio
	if (DIV < 2 || DIV > 255)
	begin : g_bad_div
		$error("DIV out of range");
	end
	// Count and wrap
	always_comb
	begin
		cur_nxt = cur_r;
		if (!en)
			cur_nxt.cnt = 8'h00;
		else if (cur_r.cnt == 8'(DIV - 1))
			cur_nxt.cnt = 8'h00;
		else
			cur_nxt.cnt = cur_r.cnt + 8'h01;
	end
	// Register the state
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cur_r <= '0;
		else
			cur_r <= cur_nxt;
	end
	assign tick = en && (cur_r.cnt == 8'(DIV - 1)); // Rate fixed by DIV, no RC trim input
endmodule : fsp_tick_div

/* rtl/fsp_flash_dev.sv */
// Flash self-program sequencer: holding buffer, control, key and array.
// Assumes the core keeps each request steady until ack and loads rows in order.
`timescale 1ns/1ps
// Notes on behaviour
// - Rows hold 64 words, 192 bytes
// - Erase acts on aligned eight-row pages
// - Program a whole row or one word
// - Holding buffer keeps 64 words for rows
// - Core fills buffer in sequential order
// - Buffered words share one 64-word group
// - Full row needs 64 low/high write pairs
// - Table writes touch buffer only, two cycles
// - One start programs only the buffered row
// - Core stalled until operation finishes
// - Duration counted in fast RC ticks
// - Row write lasts 11064 RC ticks
// - Target address is page joined with EA
// - Low table ops reach bits 15:0
// - High table ops reach bits 23:16
// - Operations start only via control bits
// - Data window suspended during table ops
// - Key 55 then AA must precede start
// - Start bit self-clears when done
// - Code 0001, erase clear, programs a row
// - Code 0010, erase set, erases a page
module fsp_flash_dev #(
	parameter int ARRAY_WORDS = 1024,                // Array size, whole pages
	parameter int ROW_TICKS   = fsp_pkg::ROW_TICKS,  // Row write length
	parameter int WORD_TICKS  = fsp_pkg::WORD_TICKS, // Word write length
	parameter int ERASE_TICKS = fsp_pkg::ERASE_TICKS // Page erase length
) (
	input  wire logic  sys_clk,  // System clock
	input  wire logic  rst,      // Async reset
	fsp_link_if.dev    bus,      // Core side
	input  wire logic [22:0] peekIdx, // Word index to observe
	output logic [23:0] peekWord, // Array word at peekIdx
	output logic        opBusy    // Operation running
);
	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		logic [7:0]  page;     // Table page select
		logic        start;    // Operation running
		logic        enable;   // Program/erase enable
		logic        err;      // Bad sequence flag
		logic        erase;    // Erase select
		logic [3:0]  op;       // Operation select field
		fsp_pkg::fsp_key_type keyStage; // Unlock progress
		logic        ack;      // Answer to the taken request
		logic [15:0] rdata;    // Read answer
		logic [23:0] tgt;      // Address of last table write
		logic [15:0] ticks;    // RC ticks elapsed
		logic [fsp_pkg::ROW_WORDS-1:0][23:0] holdBuf; // Holding buffer
		logic [ARRAY_WORDS-1:0][23:0] mem; // Flash array
		logic [23:0] peek;     // Observed word
	} fsp_dev_state_type;
	fsp_dev_state_type cur_r, cur_nxt;
	logic        tick;   // RC tick enable
	logic        take;   // Request taken this cycle
	logic [23:0] addr;   // Table target address
	logic [23:0] word;   // Array word at addr
	logic        wrGo;   // Start bit write attempt
	int          base;   // First word index of a row or page
	if (ARRAY_WORDS % fsp_pkg::PAGE_WORDS != 0 || ROW_TICKS > 65535
		|| WORD_TICKS > 65535 || ERASE_TICKS > 65535 || WORD_TICKS < 1
		|| ERASE_TICKS < 1 || ROW_TICKS < 1)
	begin : g_bad_param
		$error("fsp_flash_dev parameters out of range");
	end
	// ************************************************
	// Decoding
	// ************************************************
	// Only the three documented codes run; a start with any other code sets err instead
	function automatic logic opValid(input logic erase, input logic [3:0] op);
		opValid = erase ? (op == fsp_pkg::OP_PAGE)
			: (op == fsp_pkg::OP_ROW || op == fsp_pkg::OP_WORD);
	endfunction : opValid
	// Length of the selected operation in RC ticks
	function automatic logic [15:0] opTicks(input logic erase, input logic [3:0] op);
		if (erase)
			opTicks = 16'(ERASE_TICKS);
		else if (op == fsp_pkg::OP_ROW)
			opTicks = 16'(ROW_TICKS);
		else
			opTicks = 16'(WORD_TICKS);
	endfunction : opTicks
	// Array read, zero outside the array
	function automatic logic [23:0] memRead(input fsp_dev_state_type s,
		input logic [22:0] idx);
		memRead = (int'(idx) < ARRAY_WORDS) ? s.mem[idx] : 24'h000000;
	endfunction : memRead
	// ************************************************
	// RC tick source
	// ************************************************
	fsp_tick_div u_div (
		.sys_clk (sys_clk),
		.rst     (rst),
		.en      (cur_r.start),
		.tick    (tick)
	);
	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		cur_nxt = cur_r;
		base = 0;
		// Requests wait while an operation runs
		take = bus.req && !cur_r.ack && !cur_r.start;
		cur_nxt.ack = take;
		addr = {cur_r.page, bus.ea};
		word = memRead(cur_r, addr[23:1]);
		wrGo = take && bus.kind == fsp_pkg::K_REG_WR && bus.regSel == fsp_pkg::SEL_CTRL
			&& bus.wdata[fsp_pkg::CTL_START];
		cur_nxt.peek = memRead(cur_r, peekIdx);
		if (take)
		begin
			// Any other request breaks the key pair
			if (!(bus.kind == fsp_pkg::K_REG_WR && bus.regSel == fsp_pkg::SEL_KEY))
				cur_nxt.keyStage = fsp_pkg::KS_IDLE;
			unique case (bus.kind)
				fsp_pkg::K_REG_WR:
				begin
					if (bus.regSel == fsp_pkg::SEL_PAGE)
						cur_nxt.page = bus.wdata[7:0];
					else if (bus.regSel == fsp_pkg::SEL_CTRL)
					begin
						cur_nxt.enable = bus.wdata[fsp_pkg::CTL_EN];
						cur_nxt.erase  = bus.wdata[fsp_pkg::CTL_ERASE];
						cur_nxt.op     = bus.wdata[3:0];
						cur_nxt.err    = bus.wdata[fsp_pkg::CTL_ERR];
						// Start only after the key pair and with a valid code
						if (wrGo && cur_r.keyStage == fsp_pkg::KS_ARMED
							&& bus.wdata[fsp_pkg::CTL_EN]
							&& opValid(bus.wdata[fsp_pkg::CTL_ERASE], bus.wdata[3:0]))
						begin
							cur_nxt.start = 1'b1;
							cur_nxt.ticks = 16'h0000;
						end
						else if (wrGo)
							cur_nxt.err = 1'b1; // Set wins over a write of zero
					end
					else if (bus.regSel == fsp_pkg::SEL_KEY)
					begin
						// Key pair must come on consecutive requests
						if (bus.wdata[7:0] == fsp_pkg::KEY_FIRST)
							cur_nxt.keyStage = fsp_pkg::KS_HALF;
						else if (bus.wdata[7:0] == fsp_pkg::KEY_SECOND
							&& cur_r.keyStage == fsp_pkg::KS_HALF)
							cur_nxt.keyStage = fsp_pkg::KS_ARMED;
						else
							cur_nxt.keyStage = fsp_pkg::KS_IDLE;
					end
				end
				fsp_pkg::K_REG_RD:
				begin
					// Key reads as zero; unused control bits read zero
					if (bus.regSel == fsp_pkg::SEL_PAGE)
						cur_nxt.rdata = {8'h00, cur_r.page};
					else if (bus.regSel == fsp_pkg::SEL_CTRL)
						cur_nxt.rdata = {cur_r.start, cur_r.enable, cur_r.err, 6'h00,
							cur_r.erase, 2'h0, cur_r.op};
					else
						cur_nxt.rdata = 16'h0000;
				end
				fsp_pkg::K_TBL_WR:
				begin
					// Buffer only, slot picked by address bits 6:1
					cur_nxt.tgt = addr;
					if (bus.high)
					begin
						if (!(bus.byteMode && bus.byteSel)) // Phantom byte ignored
							cur_nxt.holdBuf[addr[6:1]][23:16] = bus.wdata[7:0];
					end
					else if (!bus.byteMode)
						cur_nxt.holdBuf[addr[6:1]][15:0] = bus.wdata;
					else if (bus.byteSel)
						cur_nxt.holdBuf[addr[6:1]][15:8] = bus.wdata[7:0];
					else
						cur_nxt.holdBuf[addr[6:1]][7:0] = bus.wdata[7:0];
				end
				fsp_pkg::K_TBL_RD:
				begin
					if (bus.high)
						cur_nxt.rdata = (bus.byteMode && bus.byteSel) ? 16'h0000
							: {8'h00, word[23:16]};
					else if (bus.byteMode)
						cur_nxt.rdata = {8'h00, bus.byteSel ? word[15:8] : word[7:0]};
					else
						cur_nxt.rdata = word[15:0];
				end
			endcase
		end
		// Self-timed operation, counted in RC ticks
		if (cur_r.start && tick)
		begin
			cur_nxt.ticks = cur_r.ticks + 16'h0001;
			if (cur_nxt.ticks == opTicks(cur_r.erase, cur_r.op))
			begin
				cur_nxt.start = 1'b0;
				cur_nxt.keyStage = fsp_pkg::KS_IDLE;
				if (cur_r.erase)
				begin
					// Page boundary from address bit 10 up
					base = int'(cur_r.tgt[23:fsp_pkg::PAGE_LSB]) * fsp_pkg::PAGE_WORDS;
					for (int i = 0; i < fsp_pkg::PAGE_WORDS; i++)
						if (base + i < ARRAY_WORDS)
							cur_nxt.mem[base + i] = fsp_pkg::ERASED_WORD;
				end
				else if (cur_r.op == fsp_pkg::OP_ROW)
				begin
					// Whole buffered row, one row per start
					base = int'(cur_r.tgt[23:fsp_pkg::ROW_LSB]) * fsp_pkg::ROW_WORDS;
					for (int i = 0; i < fsp_pkg::ROW_WORDS; i++)
						if (base + i < ARRAY_WORDS)
							cur_nxt.mem[base + i] = cur_r.holdBuf[i];
				end
				else
				begin
					// Single word, neighbours untouched
					base = int'(cur_r.tgt[23:fsp_pkg::SLOT_LSB]);
					if (base < ARRAY_WORDS)
						cur_nxt.mem[base] = cur_r.holdBuf[cur_r.tgt[6:1]];
				end
			end
		end
	end
	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cur_r <= '0;
		else
			cur_r <= cur_nxt;
	end
	// ************************************************
	// Outputs
	// ************************************************
	assign bus.ack   = cur_r.ack;
	assign bus.rdata = cur_r.rdata;
	assign bus.stall = cur_r.start;
	// Window off from the request until its answer
	assign bus.windowSuspend = bus.req && !cur_r.start
		&& (bus.kind == fsp_pkg::K_TBL_WR || bus.kind == fsp_pkg::K_TBL_RD);
	assign peekWord = cur_r.peek;
	assign opBusy   = cur_r.start;
endmodule : fsp_flash_dev

/* rtl/fsp_core_end.sv */
// Core end: turns APB commands into table and control sequences.
// Assumes zero-wait APB from the same clock and the device on the link.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module fsp_core_end (
	input  wire logic        sys_clk, // System clock
	input  wire logic        rst,     // Async reset
	fsp_link_if.core         bus,     // Device side
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB access phase
	input  wire logic        pwrite,  // APB direction
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic [31:0]      prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr  // APB error, unmapped
);
	// ************************************************
	// State
	// ************************************************
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000, S_PAGE = 4'b0001, S_WRLO = 4'b0011, S_WRHI = 4'b0010,
		S_CTRL = 4'b0110, S_K55 = 4'b0111, S_KAA = 4'b0101, S_GO = 4'b0100,
		S_WAIT = 4'b1100, S_RDLO = 4'b1101, S_RDHI = 4'b1111
	} fsp_core_fsm_type;
	typedef struct packed {
		fsp_core_fsm_type fsm;  // Sequence step
		logic [2:0]  cmd;       // Command in progress
		logic [23:0] addr;      // Target address
		logic [23:0] wdata;     // Word to write
		logic [23:0] rdata;     // Word read back
		logic [5:0]  loadIdx;   // Next buffer slot
		logic        refused;   // Command while busy
		logic        req;       // Link request
		fsp_pkg::fsp_kind_type kind;
		logic [1:0]  regSel;
		logic        high;
		logic [15:0] ea;
		logic [15:0] wd;
	} fsp_core_state_type;
	fsp_core_state_type cur_r, cur_nxt;
	logic             wr;   // APB write this cycle
	fsp_core_fsm_type step; // Step after the answer
	logic [1:0]       kind; // Request kind of this step
	logic [1:0]       sel;
	logic             hi;
	logic [15:0]      ea;
	logic [15:0]      wd;
	// ************************************************
	// Sequencer
	// ************************************************
	always_comb
	begin
		cur_nxt = cur_r;
		wr   = psel && penable && pwrite;
		step = cur_r.fsm;
		kind = fsp_pkg::K_REG_WR;
		sel  = fsp_pkg::SEL_PAGE;
		hi   = 1'b0;
		ea   = cur_r.addr[15:0];
		wd   = 16'h0000;
		// Register writes from software
		if (wr && paddr == fsp_pkg::A_ADDR)
		begin
			cur_nxt.addr = pwdata[23:0];
			cur_nxt.loadIdx = 6'h00; // New row restarts the fill
		end
		if (wr && paddr == fsp_pkg::A_WDATA)
			cur_nxt.wdata = pwdata[23:0];
		if (wr && paddr == fsp_pkg::A_CMD && cur_r.fsm != S_IDLE)
			cur_nxt.refused = 1'b1;
		unique case (cur_r.fsm)
			S_IDLE:
				if (wr && paddr == fsp_pkg::A_CMD)
				begin
					cur_nxt.cmd = pwdata[2:0];
					cur_nxt.refused = 1'b0;
					if (pwdata[2:0] == fsp_pkg::CMD_ROW)
						cur_nxt.fsm = S_CTRL; // Buffer already loaded
					else if (pwdata[2:0] >= fsp_pkg::CMD_LOAD
						&& pwdata[2:0] <= fsp_pkg::CMD_READ)
						cur_nxt.fsm = S_PAGE;
				end
			S_PAGE:
			begin
				wd = {8'h00, cur_r.addr[23:16]};
				step = (cur_r.cmd == fsp_pkg::CMD_READ) ? S_RDLO : S_WRLO;
			end
			S_WRLO:
			begin
				// Loads walk the slots in order inside one row
				kind = fsp_pkg::K_TBL_WR;
				if (cur_r.cmd == fsp_pkg::CMD_LOAD)
					ea = {cur_r.addr[15:7], cur_r.loadIdx, 1'b0};
				wd = cur_r.wdata[15:0];
				step = S_WRHI;
			end
			S_WRHI:
			begin
				kind = fsp_pkg::K_TBL_WR;
				hi = 1'b1;
				if (cur_r.cmd == fsp_pkg::CMD_LOAD)
					ea = {cur_r.addr[15:7], cur_r.loadIdx, 1'b0};
				wd = {8'h00, cur_r.wdata[23:16]};
				step = (cur_r.cmd == fsp_pkg::CMD_LOAD) ? S_IDLE : S_CTRL;
			end
			// Control word is rebuilt for the start write; link data then holds the key
			S_CTRL, S_GO:
			begin
				sel = fsp_pkg::SEL_CTRL;
				wd[fsp_pkg::CTL_START] = (cur_r.fsm == S_GO);
				wd[fsp_pkg::CTL_EN] = 1'b1;
				wd[fsp_pkg::CTL_ERASE] = (cur_r.cmd == fsp_pkg::CMD_ERASE);
				wd[3:0] = (cur_r.cmd == fsp_pkg::CMD_ERASE) ? fsp_pkg::OP_PAGE
					: (cur_r.cmd == fsp_pkg::CMD_ROW) ? fsp_pkg::OP_ROW
					: fsp_pkg::OP_WORD;
				step = (cur_r.fsm == S_GO) ? S_WAIT : S_K55;
			end
			S_K55:
			begin
				sel = fsp_pkg::SEL_KEY;
				wd = {8'h00, fsp_pkg::KEY_FIRST};
				step = S_KAA;
			end
			S_KAA:
			begin
				sel = fsp_pkg::SEL_KEY;
				wd = {8'h00, fsp_pkg::KEY_SECOND};
				step = S_GO;
			end
			S_WAIT:
				if (!bus.stall)
				begin
					cur_nxt.fsm = S_IDLE; // Each row needs its own start
					if (cur_r.cmd == fsp_pkg::CMD_ROW)
						cur_nxt.loadIdx = 6'h00;
				end
			S_RDLO:
			begin
				kind = fsp_pkg::K_TBL_RD;
				step = S_RDHI;
			end
			S_RDHI:
			begin
				kind = fsp_pkg::K_TBL_RD;
				hi = 1'b1;
				step = S_IDLE;
			end
		endcase
		// Common request handshake for the link steps
		if (cur_r.fsm != S_IDLE && cur_r.fsm != S_WAIT)
		begin
			if (!cur_r.req)
			begin
				cur_nxt.req    = 1'b1;
				cur_nxt.kind   = fsp_pkg::fsp_kind_type'(kind);
				cur_nxt.regSel = sel;
				cur_nxt.high   = hi;
				cur_nxt.ea     = ea;
				cur_nxt.wd     = wd;
			end
			else if (bus.ack)
			begin
				cur_nxt.req = 1'b0;
				cur_nxt.fsm = step;
				if (cur_r.fsm == S_RDLO)
					cur_nxt.rdata[15:0] = bus.rdata;
				if (cur_r.fsm == S_RDHI)
					cur_nxt.rdata[23:16] = bus.rdata[7:0];
				if (cur_r.fsm == S_WRHI && cur_r.cmd == fsp_pkg::CMD_LOAD)
					cur_nxt.loadIdx = cur_r.loadIdx + 6'h01;
			end
		end
	end
	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cur_r <= '0;
		else
			cur_r <= cur_nxt;
	end
	// ************************************************
	// Outputs
	// ************************************************
	assign bus.req      = cur_r.req;
	assign bus.kind     = cur_r.kind;
	assign bus.regSel   = cur_r.regSel;
	assign bus.high     = cur_r.high;
	assign bus.byteMode = 1'b0; // Word accesses only from this end
	assign bus.byteSel  = 1'b0;
	assign bus.ea       = cur_r.ea;
	assign bus.wdata    = cur_r.wd;
	assign pready       = 1'b1; // Every access completes at once
	// Read mux and unmapped detection
	always_comb
	begin
		prdata  = 32'h00000000;
		pslverr = 1'b0;
		unique case (paddr)
			fsp_pkg::A_CMD:    prdata = {29'h0, cur_r.cmd};
			fsp_pkg::A_ADDR:   prdata = {8'h00, cur_r.addr};
			fsp_pkg::A_WDATA:  prdata = {8'h00, cur_r.wdata};
			fsp_pkg::A_STATUS:
			begin
				prdata[fsp_pkg::ST_BUSY] = (cur_r.fsm != S_IDLE);
				prdata[fsp_pkg::ST_REFUSED] = cur_r.refused;
				prdata[fsp_pkg::ST_IDX_LSB +: 6] = cur_r.loadIdx;
			end
			fsp_pkg::A_RDATA:  prdata = {8'h00, cur_r.rdata};
			default:           pslverr = psel && penable;
		endcase
	end
endmodule : fsp_core_end

/* sim/fsp_link_props.sv */
// Checker for the link between the core end and the flash sequencer.
// Assumes the testbench wires it to the link and sets all op lengths to 4 RC ticks.
`timescale 1ns/1ps
module fsp_link_props (
	input wire logic                  sys_clk,       // System clock
	input wire logic                  rst,           // Async reset
	input wire logic                  req,           // Core request
	input wire fsp_pkg::fsp_kind_type kind,          // Request kind
	input wire logic                  ack,           // Device answer
	input wire logic                  stall,         // Core held
	input wire logic                  windowSuspend  // Data window off
);
	// ****************************************
	// Link timing
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Answer exactly one cycle after a taken request
	take_ack_a: assert property (req && !ack && !stall |=> ack) else $error("late ack");
	ack_pulse_a: assert property (ack |=> !ack) else $error("long ack");
	req_hold_a: assert property (req && !ack |=> req) else $error("req dropped");
	req_drop_a: assert property (ack |=> !req) else $error("req held");
	// Stall starts with the ack of the control write
	stall_start_a: assert property ($rose(stall) |-> ack && kind == fsp_pkg::K_REG_WR)
		else $error("stall start");
	stall_hold_a: assert property ($rose(stall) |-> stall[*8]) else $error("short stall");
	// 4 ticks of 27 cycles, two cycles of slack either side
	stall_len_a: assert property ($rose(stall) |-> ##[106:110] $fell(stall))
		else $error("stall length");
	stall_quiet_a: assert property (stall && $past(stall) |-> !ack) else $error("ack in stall");
	win_on_a: assert property (req && kind == fsp_pkg::K_TBL_WR && !stall |-> windowSuspend)
		else $error("window on");
	win_off_a: assert property (stall |-> !windowSuspend) else $error("window off");
endmodule : fsp_link_props

/* sim/test_flash_self_program_sequencer.sv */
// Testbench: APB drives the core end, which drives the flash sequencer.
// Assumes short op lengths of 4 RC ticks; array word index is address/2.
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, opBusy, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [22:0] peekIdx;
	logic [23:0] peekWord;
	int          badCount, checksDone;
	localparam int OP_TICKS = 4; // Short op length for every operation
	fsp_link_if fsp_link_if_i ();
	fsp_flash_dev #(.ROW_TICKS(OP_TICKS), .WORD_TICKS(OP_TICKS), .ERASE_TICKS(OP_TICKS))
		fsp_flash_dev_i (.sys_clk, .rst, .bus(fsp_link_if_i), .peekIdx, .peekWord, .opBusy);
	fsp_core_end fsp_core_end_i (.sys_clk, .rst, .bus(fsp_link_if_i), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	fsp_link_props fsp_link_props_i (.sys_clk, .rst, .req(fsp_link_if_i.req),
		.kind(fsp_link_if_i.kind), .ack(fsp_link_if_i.ack), .stall(fsp_link_if_i.stall),
		.windowSuspend(fsp_link_if_i.windowSuspend));
	// ****************************************
	// Helpers
	// ****************************************
	function logic [23:0] pat(input int i);
		return {8'(i) + 8'h10, 8'h3c, 8'(i)};
	endfunction : pat
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			badCount++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; extra edge keeps drivers single per step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	// Poll busy, watchdog catches a hang
	task idle;
		do apb(0, fsp_pkg::A_STATUS, 0); while (rd[fsp_pkg::ST_BUSY] !== 1'b0);
	endtask : idle
	task cmd(input logic [23:0] ad, input logic [2:0] c);
		apb(1, fsp_pkg::A_ADDR, {8'h0, ad});
		apb(1, fsp_pkg::A_CMD, {29'h0, c});
		idle();
	endtask : cmd
	task pk(input logic [22:0] i, input logic [23:0] e);
		peekIdx <= i;
		repeat (2) @(posedge sys_clk);
		chk({8'h0, peekWord}, {8'h0, e});
	endtask : pk
	// ****************************************
	// Scenarios
	// ****************************************
	task sErase; // Page 1 erased, page 0 untouched, busy length counted
		int n;
		apb(1, fsp_pkg::A_ADDR, 32'h00000400);
		apb(1, fsp_pkg::A_CMD, {29'h0, fsp_pkg::CMD_ERASE});
		do @(posedge sys_clk); while (opBusy !== 1'b1);
		n = 0;
		while (opBusy === 1'b1)
		begin
			n++;
			@(posedge sys_clk);
		end
		chk(n, OP_TICKS * fsp_pkg::FRC_DIV);
		idle();
		pk(23'h200, 24'hffffff);
		pk(23'h3ff, 24'hffffff);
		pk(23'h1ff, 24'h0);
	endtask : sErase
	task sRow; // Full row, erase refused while busy
		apb(1, fsp_pkg::A_ADDR, 32'h480);
		for (int i = 0; i < 64; i++)
		begin
			apb(1, fsp_pkg::A_WDATA, {8'h0, pat(i)});
			apb(1, fsp_pkg::A_CMD, {29'h0, fsp_pkg::CMD_LOAD});
			idle();
		end
		apb(1, fsp_pkg::A_CMD, {29'h0, fsp_pkg::CMD_ROW});
		apb(1, fsp_pkg::A_CMD, {29'h0, fsp_pkg::CMD_ERASE});
		apb(0, fsp_pkg::A_STATUS, 0);
		chk({30'h0, rd[1:0]}, 32'h3);
		idle();
		pk(23'h240, pat(0));
		pk(23'h27f, pat(63));
		pk(23'h280, 24'hffffff);
	endtask : sRow
	task sWord; // One word changes, its neighbour stays erased
		apb(1, fsp_pkg::A_WDATA, 32'h123456);
		cmd(24'h000402, fsp_pkg::CMD_WORD);
		pk(23'h201, 24'h123456);
		pk(23'h202, 24'hffffff);
	endtask : sWord
	task sRead; // Both halves read back, unmapped place errors
		cmd(24'h000482, fsp_pkg::CMD_READ);
		apb(0, fsp_pkg::A_RDATA, 0);
		chk(rd, {8'h0, pat(1)});
		apb(0, 8'h20, 0);
		chk({31'h0, err}, 32'h1);
	endtask : sRead
	task endOfTest;
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : endOfTest
	initial
	begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		badCount++;
		endOfTest();
	end
	initial
	begin
		rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; peekIdx = 0;
		badCount = 0; checksDone = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		sErase(); sRow(); sWord(); sRead();
		endOfTest();
	end
endmodule : test_flash_self_program_sequencer
